// ===== pkg/omcc_pkg.sv
// Constants, field layout and state types for the operating mode clock control.
// Assumes a single 250 MHz core clock; oscillator cycles arrive as enable ticks.
package omcc_pkg;

	// ============================================================
	// Register map
	localparam int REG_ADDR_W = 2;
	localparam logic [REG_ADDR_W-1:0] CMC_OFFSET = 2'h0;
	localparam logic [7:0] CMC_RESET = 8'h03;
	localparam int DIV_MSB = 7;
	localparam int DIV_LSB = 5;
	localparam int QWE_BIT = 4;
	localparam int SRDY_BIT = 3;
	localparam int FRDY_BIT = 2;
	localparam int IDLE_BIT = 1;
	localparam int FULL_BIT = 0;

	// ============================================================
	// Clock selection
	localparam logic [2:0] DIV_SLOW_MAX = 3'h1;
	localparam logic [3:0] DIV_SHIFT_BASE = 4'h8;
	localparam logic [2:0] SHIFT_FULL = 3'h0;

	// ============================================================
	// Oscillator ready counts, in oscillator cycles
	localparam int RDY_W = 8;
	localparam logic [RDY_W-1:0] FAST_XTAL_CYCLES = 8'h80;
	localparam logic [RDY_W-1:0] FAST_RC_CYCLES = 8'h10;
	localparam logic [RDY_W-1:0] SLOW_RC_CYCLES = 8'h02;

	// ============================================================
	// Reported operating modes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_SLOW = 3'h1;
	localparam logic [2:0] MODE_IDLE_OSC_OFF = 3'h2;
	localparam logic [2:0] MODE_IDLE_OSC_ON = 3'h3;
	localparam logic [2:0] MODE_DEEP_SLEEP = 3'h4;
	localparam logic [2:0] MODE_SLEEP_SLOW_CLOCKS_ON = 3'h5;
	localparam logic [2:0] MODE_WAKE = 3'h6;

	// ============================================================
	// Controller states
	typedef enum logic [2:0] {
		OMCC_RUN = 3'h0,
		OMCC_WAKE = 3'h1,
		OMCC_IDLE_OSC_ON = 3'h3,
		OMCC_IDLE_OSC_OFF = 3'h2,
		OMCC_SLEEP_SLOW_CLOCKS_ON = 3'h6,
		OMCC_DEEP_SLEEP = 3'h7
	} omcc_state_t;

endpackage : omcc_pkg

// ===== hdl/omcc_ready_timer.sv
// Oscillator ready timer: counts oscillator ticks after the oscillator is enabled.
// Assumes tick is a one-cycle enable per oscillator cycle, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module omcc_ready_timer #(
	parameter int CW = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic enable,
	input wire logic tick,
	input wire logic [CW-1:0] threshold,
	output logic ready
);

	logic [CW-1:0] count_reg;

	// ============================================================
	// Tick counter, cleared while the oscillator is off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (!enable) begin
			count_reg <= '0;
		end else if (tick && (count_reg < threshold)) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// ============================================================
	// Ready flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ready <= 1'b0;
		end else begin
			ready <= enable && (count_reg >= threshold);
		end
	end

endmodule : omcc_ready_timer
`default_nettype wire

// ===== hdl/omcc_core.sv
// Operating mode and system clock control: mode sequencing, clock source choice,
// glitch-free source switching, oscillator ready flags and halt status flags.
// Assumes oscillator cycles arrive as one-cycle ticks synchronous to clk, and
// that halt, wake and strap inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Six modes: normal, slow running; idle_osc_off, idle_osc_on, deep_sleep, sleep_slow_clocks_on with CPU off.
// - Halt, no idle, watchdog and detector off: deep sleep stops all slow clocks.
// - Voltage detect on blocks deep sleep; such halt enters sleep with slow clocks.
// - Slow-clock sleep keeps wake-assist and watchdog clocks only if needed.
// - Idle with oscillator off stops system oscillator, keeps slow peripheral clocks.
// - Idle with oscillator on keeps system clock for peripherals, CPU stopped.
// - Divider select 000/001 gives slow clock, 010..111 fast over 64..2.
// - Full-speed select high gives undivided fast clock.
// - Moving to slow clock switches fast oscillator off.
// - Normal mode runs CPU from fast clock divided 1 to 64.
// - Slow ready low in deep sleep, rises 1 to 2 slow cycles later.
// - Fast ready clears when stopped, rises after 128 crystal or 15-16 RC cycles.
// - Halt enters idle if idle-on-halt set, else sleep.
// - Quick wake only with crystal; wake-assist clock then drives system.
// - Quick wake only from slow-clock sleep or oscillator-off idle.
// - Quick wake runs from wake-assist clock until fast ready, then crystal.
// - With internal RC, wake waits on oscillator ready, quick wake ignored.
// - No quick wake from deep sleep, slow oscillator is off there.
// - Halt sets power-down flag and clears watchdog expired flag.
// - Leave sleep or idle on port A falling edge or system interrupt.
module omcc_core #(
	parameter int PORTA_W = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [omcc_pkg::REG_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic external_crystal_osc,
	input wire logic watchdog_enable,
	input wire logic watchdog_on_assist,
	input wire logic voltage_detect_enable,
	input wire logic keep_sysclk_on,
	input wire logic fast_osc_tick,
	input wire logic slow_osc_tick,
	input wire logic halt,
	input wire logic sys_irq,
	input wire logic [PORTA_W-1:0] porta_in,
	input wire logic watchdog_timeout,
	input wire logic powerdown_clear,
	output logic system_clock_en,
	output logic cpu_run,
	output logic fast_osc_enable,
	output logic slow_osc_enable,
	output logic wake_assist_clock_run,
	output logic watchdog_detector_clock_run,
	output logic timebase_clock_run,
	output logic watchdog_stop,
	output logic watchdog_clear,
	output logic [2:0] op_mode,
	output logic powerdown_flag,
	output logic watchdog_expired_flag
);
	import omcc_pkg::*;

	// ============================================================
	// Declarations
	omcc_state_t state_reg;
	omcc_state_t origin_reg;
	logic [2:0] divider_select;
	logic quick_wake_enable;
	logic idle_on_halt;
	logic full_speed_select;
	logic fast_osc_ready;
	logic slow_osc_ready;
	logic assist_reg;
	logic active_slow_reg;
	logic [2:0] active_shift_reg;
	logic [5:0] div_cnt_reg;
	logic [PORTA_W-1:0] porta_prev_reg;
	logic [5:0] div_mask;
	logic fast_pulse;
	logic src_pulse;
	logic gate_on;
	logic reg_wants_slow;
	logic target_slow;
	logic [2:0] target_shift;
	logic target_ready;
	logic switch_now;
	logic low_power;
	logic wake_event;
	logic halt_take;
	logic quick_ok;
	logic fast_need;
	logic assist_need;
	logic [RDY_W-1:0] fast_threshold;

	function automatic logic [2:0] shift_of(input logic full, input logic [2:0] div);
		if (full) begin
			return SHIFT_FULL;
		end
		return 3'(DIV_SHIFT_BASE - {1'b0, div});
	endfunction : shift_of

	// ============================================================
	// Control register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divider_select <= CMC_RESET[DIV_MSB:DIV_LSB];
			quick_wake_enable <= CMC_RESET[QWE_BIT];
			idle_on_halt <= CMC_RESET[IDLE_BIT];
			full_speed_select <= CMC_RESET[FULL_BIT];
		end else if (reg_wr && (reg_addr == CMC_OFFSET)) begin
			divider_select <= reg_wdata[DIV_MSB:DIV_LSB];
			quick_wake_enable <= reg_wdata[QWE_BIT];
			idle_on_halt <= reg_wdata[IDLE_BIT];
			full_speed_select <= reg_wdata[FULL_BIT];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && (reg_addr == CMC_OFFSET)) begin
			reg_rdata <= {divider_select, quick_wake_enable, slow_osc_ready,
				fast_osc_ready, idle_on_halt, full_speed_select};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ============================================================
	// Clock source choice
	// Divider select decode
	assign reg_wants_slow = !full_speed_select && (divider_select <= DIV_SLOW_MAX);
	assign target_slow = assist_reg || reg_wants_slow;
	assign target_shift = shift_of(full_speed_select, divider_select);
	assign target_ready = target_slow ? slow_osc_ready : fast_osc_ready;
	assign gate_on = (state_reg == OMCC_RUN) || (state_reg == OMCC_IDLE_OSC_ON);
	// Fast divide by power of two
	assign div_mask = 6'((7'h01 << active_shift_reg) - 7'h01);
	assign fast_pulse = fast_osc_tick && ((div_cnt_reg & div_mask) == div_mask);
	assign src_pulse = active_slow_reg ? slow_osc_tick : fast_pulse;
	assign switch_now = ((target_slow != active_slow_reg) ||
		(!target_slow && (target_shift != active_shift_reg))) &&
		target_ready && (src_pulse || !gate_on);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			active_slow_reg <= 1'b0;
			active_shift_reg <= SHIFT_FULL;
		end else if (switch_now) begin
			active_slow_reg <= target_slow;
			active_shift_reg <= target_slow ? active_shift_reg : target_shift;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_reg <= 6'h00;
		end else if (switch_now) begin
			div_cnt_reg <= 6'h00;
		end else if (fast_osc_tick) begin
			div_cnt_reg <= div_cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			system_clock_en <= 1'b0;
		end else begin
			system_clock_en <= src_pulse && gate_on && !switch_now;
		end
	end

	// ============================================================
	// Mode sequencing
	assign low_power = (state_reg == OMCC_IDLE_OSC_OFF) || (state_reg == OMCC_IDLE_OSC_ON) ||
		(state_reg == OMCC_DEEP_SLEEP) || (state_reg == OMCC_SLEEP_SLOW_CLOCKS_ON);
	// Port A falling edge or interrupt
	assign wake_event = sys_irq || (|(porta_prev_reg & ~porta_in));
	assign halt_take = halt && (state_reg == OMCC_RUN);
	assign quick_ok = external_crystal_osc && quick_wake_enable &&
		((origin_reg == OMCC_SLEEP_SLOW_CLOCKS_ON) || (origin_reg == OMCC_IDLE_OSC_OFF));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			porta_prev_reg <= '0;
		end else begin
			porta_prev_reg <= porta_in;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= OMCC_RUN;
			origin_reg <= OMCC_RUN;
		end else begin
			unique case (state_reg)
				OMCC_RUN: begin
					if (halt) begin
						if (idle_on_halt) begin
							state_reg <= keep_sysclk_on ? OMCC_IDLE_OSC_ON : OMCC_IDLE_OSC_OFF;
						end else if (watchdog_enable || voltage_detect_enable) begin
							state_reg <= OMCC_SLEEP_SLOW_CLOCKS_ON;
						end else begin
							state_reg <= OMCC_DEEP_SLEEP;
						end
					end
				end
				OMCC_IDLE_OSC_ON: begin
					if (wake_event) begin
						state_reg <= OMCC_RUN;
					end
				end
				OMCC_IDLE_OSC_OFF, OMCC_DEEP_SLEEP, OMCC_SLEEP_SLOW_CLOCKS_ON: begin
					if (wake_event) begin
						origin_reg <= state_reg;
						state_reg <= OMCC_WAKE;
					end
				end
				OMCC_WAKE: begin
					if (reg_wants_slow ? slow_osc_ready : fast_osc_ready) begin
						state_reg <= OMCC_RUN;
					end else if (quick_ok && slow_osc_ready) begin
						state_reg <= OMCC_RUN;
					end
				end
				default: begin
					state_reg <= OMCC_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			assist_reg <= 1'b0;
		end else if (fast_osc_ready || (state_reg != OMCC_WAKE && state_reg != OMCC_RUN)) begin
			assist_reg <= 1'b0;
		end else if ((state_reg == OMCC_WAKE) && quick_ok && slow_osc_ready &&
			!reg_wants_slow) begin
			assist_reg <= 1'b1;
		end
	end

	// ============================================================
	// Oscillator and clock enables
	// Fast off once register-selected slow is active
	assign fast_need = ((state_reg == OMCC_RUN) || (state_reg == OMCC_WAKE) ||
		(state_reg == OMCC_IDLE_OSC_ON)) && (!reg_wants_slow || !active_slow_reg);
	// Slow-clock sleep keeps what is needed
	assign assist_need = (state_reg == OMCC_SLEEP_SLOW_CLOCKS_ON) ?
		(voltage_detect_enable || (watchdog_enable && watchdog_on_assist)) :
		(state_reg != OMCC_DEEP_SLEEP);
	assign fast_threshold = external_crystal_osc ? FAST_XTAL_CYCLES : FAST_RC_CYCLES;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fast_osc_enable <= 1'b1;
			slow_osc_enable <= 1'b1;
			wake_assist_clock_run <= 1'b1;
			watchdog_detector_clock_run <= 1'b1;
			timebase_clock_run <= 1'b1;
			cpu_run <= 1'b0;
			watchdog_stop <= 1'b0;
		end else begin
			fast_osc_enable <= fast_need;
			// Slow oscillator off in deep sleep
			slow_osc_enable <= (state_reg != OMCC_DEEP_SLEEP);
			wake_assist_clock_run <= assist_need;
			watchdog_detector_clock_run <= assist_need;
			// Time base runs in both idles
			timebase_clock_run <= (state_reg != OMCC_DEEP_SLEEP) && (state_reg != OMCC_SLEEP_SLOW_CLOCKS_ON);
			cpu_run <= (state_reg == OMCC_RUN);
			watchdog_stop <= (state_reg == OMCC_DEEP_SLEEP);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			op_mode <= MODE_NORMAL;
		end else begin
			unique case (state_reg)
				OMCC_RUN: op_mode <= active_slow_reg ? MODE_SLOW : MODE_NORMAL;
				OMCC_WAKE: op_mode <= MODE_WAKE;
				OMCC_IDLE_OSC_OFF: op_mode <= MODE_IDLE_OSC_OFF;
				OMCC_IDLE_OSC_ON: op_mode <= MODE_IDLE_OSC_ON;
				OMCC_DEEP_SLEEP: op_mode <= MODE_DEEP_SLEEP;
				OMCC_SLEEP_SLOW_CLOCKS_ON: op_mode <= MODE_SLEEP_SLOW_CLOCKS_ON;
				default: op_mode <= MODE_NORMAL;
			endcase
		end
	end

	// ============================================================
	// Ready timers
	// Fast ready count
	omcc_ready_timer #(.CW(RDY_W)) u_fast_ready (
		.clk(clk),
		.nrst(nrst),
		.enable(fast_osc_enable),
		.tick(fast_osc_tick),
		.threshold(fast_threshold),
		.ready(fast_osc_ready)
	);

	omcc_ready_timer #(.CW(RDY_W)) u_slow_ready (
		.clk(clk),
		.nrst(nrst),
		.enable(slow_osc_enable),
		.tick(slow_osc_tick),
		.threshold(SLOW_RC_CYCLES),
		.ready(slow_osc_ready)
	);

	// ============================================================
	// Halt status flags
	// Power-down set, expired cleared
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			powerdown_flag <= 1'b0;
			watchdog_expired_flag <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			powerdown_flag <= halt_take || (powerdown_flag && !powerdown_clear);
			watchdog_expired_flag <= watchdog_timeout || (watchdog_expired_flag && !halt_take);
			watchdog_clear <= halt_take;
		end
	end

	// ============================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_cpu_off_lowpower: assert property (state_reg != OMCC_RUN |=> !cpu_run)
		else $error("cpu runs outside run state");
	a_deep_sleep_entry: assert property (halt_take && !idle_on_halt && !watchdog_enable &&
		!voltage_detect_enable |=> state_reg == OMCC_DEEP_SLEEP ##1 !wake_assist_clock_run &&
		watchdog_stop) else $error("deep sleep not entered");
	a_detect_blocks_sleep: assert property (halt_take && !idle_on_halt &&
		voltage_detect_enable |=> state_reg == OMCC_SLEEP_SLOW_CLOCKS_ON ##1 wake_assist_clock_run)
		else $error("deep sleep entered with detect on");
	a_idle_osc_off: assert property (state_reg == OMCC_IDLE_OSC_OFF |=> !fast_osc_enable &&
		timebase_clock_run && !system_clock_en) else $error("idle_osc_off clocks wrong");
	a_idle_osc_on: assert property (state_reg == OMCC_IDLE_OSC_ON && !reg_wants_slow |=>
		fast_osc_enable && !cpu_run) else $error("idle_osc_on clocks wrong");
	a_slow_fast_off: assert property (state_reg == OMCC_RUN && active_slow_reg &&
		reg_wants_slow |=> !fast_osc_enable) else $error("fast osc left on in slow mode");
	a_fast_ready_clear: assert property (!fast_osc_enable |=> !fast_osc_ready)
		else $error("fast ready high while stopped");
	a_halt_flags: assert property (halt_take && !watchdog_timeout |=> powerdown_flag &&
		!watchdog_expired_flag && watchdog_clear) else $error("halt flags wrong");
	a_wake_on_irq: assert property (low_power && sys_irq |=> state_reg == OMCC_WAKE ||
		state_reg == OMCC_RUN) else $error("interrupt did not wake");
	a_switch_boundary: assert property ($changed(active_slow_reg) |->
		$past(src_pulse) || !$past(gate_on)) else $error("source switched mid period");

endmodule : omcc_core
`default_nettype wire

// ===== testbench/omcc_osc_model.sv
// Oscillator model for the operating mode clock control core.
// Assumes one core clock; each oscillator tick is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module omcc_osc_model #(
	parameter int FDIV = 2,
	parameter int SDIV = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic fast_en,
	input wire logic slow_en,
	output logic fast_tick,
	output logic slow_tick
);
	logic [7:0] fcnt;
	logic [7:0] scnt;

	// ============================================================
	// Fast oscillator, silent while disabled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst || !fast_en) begin
			fcnt <= 8'h00;
			fast_tick <= 1'b0;
		end else begin
			fcnt <= (fcnt == 8'(FDIV - 1)) ? 8'h00 : fcnt + 8'h01;
			fast_tick <= (fcnt == 8'(FDIV - 1));
		end
	end

	// ============================================================
	// Slow oscillator, silent while disabled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst || !slow_en) begin
			scnt <= 8'h00;
			slow_tick <= 1'b0;
		end else begin
			scnt <= (scnt == 8'(SDIV - 1)) ? 8'h00 : scnt + 8'h01;
			slow_tick <= (scnt == 8'(SDIV - 1));
		end
	end
endmodule : omcc_osc_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking testbench for the operating mode clock control core.
// Assumes omcc_pkg and omcc_osc_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import omcc_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic xtal = 1'b0;
	logic wd_en = 1'b0;
	logic wd_assist = 1'b1;
	logic vd_en = 1'b0;
	logic keep = 1'b0;
	logic halt = 1'b0;
	logic sys_irq = 1'b0;
	logic [7:0] porta_in = 8'hff;
	logic wd_tmo = 1'b0;
	logic pd_clr = 1'b0;
	logic [7:0] reg_rdata;
	logic fast_tick, slow_tick, system_clock_en, cpu_run, fast_osc_enable, slow_osc_enable;
	logic wake_assist_clock_run, watchdog_detector_clock_run, timebase_clock_run;
	logic watchdog_stop, watchdog_clear, powerdown_flag, watchdog_expired_flag;
	logic [2:0] op_mode;
	int fail_count = 0;
	int n_tests = 0;
	int i, n, p;
	logic [7:0] r;
	logic hc;
	logic [2:0] t_in [5] = '{3'b100, 3'b000, 3'b000, 3'b001, 3'b010};
	logic [7:0] t_reg [5] = '{8'h03, 8'h03, 8'h01, 8'h01, 8'h01};
	logic [2:0] t_mode [5] = '{MODE_IDLE_OSC_ON, MODE_IDLE_OSC_OFF, MODE_DEEP_SLEEP, MODE_SLEEP_SLOW_CLOCKS_ON, MODE_SLEEP_SLOW_CLOCKS_ON};
	logic [3:0] t_gate [5] = '{4'b1110, 4'b0110, 4'b0001, 4'b0100, 4'b0100};

	always #2 clk = ~clk;

	omcc_core i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_crystal_osc(xtal),
		.watchdog_enable(wd_en), .watchdog_on_assist(wd_assist), .voltage_detect_enable(vd_en),
		.keep_sysclk_on(keep), .fast_osc_tick(fast_tick), .slow_osc_tick(slow_tick),
		.halt(halt), .sys_irq(sys_irq), .porta_in(porta_in), .watchdog_timeout(wd_tmo),
		.powerdown_clear(pd_clr), .system_clock_en(system_clock_en), .cpu_run(cpu_run),
		.fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
		.wake_assist_clock_run(wake_assist_clock_run),
		.watchdog_detector_clock_run(watchdog_detector_clock_run),
		.timebase_clock_run(timebase_clock_run), .watchdog_stop(watchdog_stop),
		.watchdog_clear(watchdog_clear), .op_mode(op_mode), .powerdown_flag(powerdown_flag),
		.watchdog_expired_flag(watchdog_expired_flag));

	omcc_osc_model i_osc (.clk(clk), .nrst(nrst), .fast_en(fast_osc_enable),
		.slow_en(slow_osc_enable), .fast_tick(fast_tick), .slow_tick(slow_tick));

	// ============================================================
	// Shared tasks
	task finish_test;
		if (fail_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task step;
		@(posedge clk);
		#1;
	endtask : step

	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// Clear pulse stands only in the cycle after the taken halt
	task do_halt(output logic clr);
		@(posedge clk);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		#1;
		clr = watchdog_clear;
		step();
	endtask : do_halt

	task wake_irq;
		@(posedge clk);
		sys_irq <= 1'b1;
		@(posedge clk);
		sys_irq <= 1'b0;
	endtask : wake_irq

	task wait_run(output int c);
		c = 0;
		while (cpu_run !== 1'b1) begin
			step();
			c++;
			if (c > 3000) begin
				fail_count++;
				finish_test();
			end
		end
	endtask : wait_run

	// Cycles between two system clock pulses
	task per(output int c);
		c = 0;
		for (int k = 0; k < 600 && system_clock_en !== 1'b1; k++) step();
		do begin
			step();
			c++;
		end while (system_clock_en !== 1'b1 && c < 600);
		if (c >= 600) begin
			fail_count++;
			finish_test();
		end
	endtask : per

	task do_reset(input logic x);
		@(posedge clk);
		nrst <= 1'b0;
		xtal <= x;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
	endtask : do_reset

	// ============================================================
	// Main sequence
	initial begin
		do_reset(1'b0);
		rd(2'h0, r);
		chk(r, CMC_RESET);
		repeat (60) step();
		rd(2'h0, r);
		chk(r, 8'h0f);
		wr(2'h1, 8'hff);
		rd(2'h1, r);
		chk(r, 8'h00);
		rd(2'h0, r);
		chk(r, 8'h0f);
		for (i = 0; i < 9; i++) begin
			wr(2'h0, (i == 8) ? 8'h0d : {i[2:0], 5'h0c});
			repeat (400) step();
			per(p);
			chk(8'(p), (i == 8) ? 8'h02 : (i < 2) ? 8'h08 : 8'(2 << (8 - i)));
			rd(2'h0, r);
			chk(r, (i == 8) ? 8'h0d : {i[2:0], 2'b01, (i > 1), 2'b00});
			chk({5'h0, op_mode}, {5'h0, (i < 2) ? MODE_SLOW : MODE_NORMAL});
			chk({7'h0, fast_osc_enable}, {7'h0, (i > 1)});
		end
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			{keep, wd_en, vd_en} <= t_in[i];
			wr(2'h0, t_reg[i]);
			repeat (100) step();
			@(posedge clk);
			wd_tmo <= 1'b1;
			@(posedge clk);
			wd_tmo <= 1'b0;
			step();
			chk({7'h0, watchdog_expired_flag}, 8'h01);
			do_halt(hc);
			chk({5'h0, op_mode}, {5'h0, t_mode[i]});
			chk({4'h0, cpu_run, hc, powerdown_flag, watchdog_expired_flag}, 8'h06);
			repeat (4) step();
			chk({4'h0, fast_osc_enable, wake_assist_clock_run, timebase_clock_run, watchdog_stop},
				{4'h0, t_gate[i]});
			chk({6'h0, watchdog_detector_clock_run, slow_osc_enable}, {6'h0, t_gate[i][2], (i != 2)});
			rd(2'h0, r);
			chk({6'h0, r[3:2]}, {6'h0, (i != 2), (i == 0)});
			do_halt(hc);
			chk({5'h0, op_mode}, {5'h0, t_mode[i]});
			chk({7'h0, hc}, 8'h00);
			if (i[0]) begin
				wake_irq();
			end else begin
				@(posedge clk);
				porta_in <= 8'hef;
				@(posedge clk);
				porta_in <= 8'hff;
			end
			wait_run(n);
			chk({7'h0, powerdown_flag}, 8'h01);
			@(posedge clk);
			pd_clr <= 1'b1;
			@(posedge clk);
			pd_clr <= 1'b0;
			repeat (2) step();
			chk({7'h0, powerdown_flag}, 8'h00);
		end
		@(posedge clk);
		{keep, wd_en, vd_en} <= 3'b010;
		do_reset(1'b1);
		repeat (400) step();
		wr(2'h0, 8'h13);
		do_halt(hc);
		chk({7'h0, hc}, 8'h01);
		wake_irq();
		wait_run(n);
		chk({7'h0, (n < 100)}, 8'h01);
		rd(2'h0, r);
		chk({7'h0, r[2]}, 8'h00);
		repeat (400) step();
		per(p);
		chk(8'(p), 8'h02);
		wr(2'h0, 8'h03);
		do_halt(hc);
		wake_irq();
		step();
		chk({5'h0, op_mode}, {5'h0, MODE_WAKE});
		wait_run(n);
		chk({7'h0, (n > 200)}, 8'h01);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
